// ### hdl/safety_switch_ctrl.sv
// Overview of operation
// - Pair-once mode: teach exactly one actuator until reset
// - Re-pairable: reteach any number of times from idle, only latest accepted
// - Accept-any: any valid actuator, no teaching
// - Limit range flashes the diagnostic indicator
// - Open guard or chain fault drops outputs
// - Short or cross-connection on outputs is fault
// - Faults checked continuously, in every state
// - Fault: diagnostic red, state indicator blinks type
// - Internal fault forces both outputs off
// - Open-close clears fault; else power cycle
// - Outputs off when actuator leaves response area
// - Safe state during fault and teaching
// - Outputs on: in range, accepted, start or auto
`timescale 1ns/1ps
`default_nettype none
module safety_switch_ctrl
	import safety_switch_pkg::*;
#(
	parameter logic [1:0] CODING_MODE = CODING_REPAIRABLE,
	parameter int BLINK_LEN = BLINK_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Actuator reader, from the transponder front end on core_clk
	input wire logic tag_present,
	input wire logic tag_valid_type,
	input wire logic [CODE_W-1:0] tag_code,
	input wire logic tag_limit_range,
	// Pins from outside
	input wire logic teach_req,
	input wire logic start_in,
	input wire logic auto_start,
	input wire logic chain_in_ch1,
	input wire logic chain_in_ch2,
	input wire logic out_short_det,
	input wire logic out_cross_det,
	input wire logic internal_fault,
	// Outputs
	output logic safety_out_ch1,
	output logic safety_out_ch2,
	output logic diagnostic_output,
	output logic [1:0] diagnostic_indicator,
	output logic state_indicator,
	output logic [2:0] fault_code,
	output logic paired
);
	// Coding mode is elaboration-time only
	if (CODING_MODE > CODING_ACCEPT_ANY) begin : g_mode_chk
		$error("Unsupported coding mode");
	end
	if (BLINK_LEN < 1 || BLINK_LEN >= (1 << BLINK_W)) begin : g_blink_chk
		$error("Blink length out of range");
	end

	////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage read only by the second
	// Auto-start strap goes through too, so a strap moved live cannot glitch the state
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	always_ff @(posedge core_clk) begin
		sync1_r <= {teach_req, start_in, auto_start, chain_in_ch1, chain_in_ch2,
			out_short_det, out_cross_det};
		sync2_r <= sync1_r;
	end
	wire teach_s = sync2_r[6];
	wire start_s = sync2_r[5];
	wire auto_s = sync2_r[4]; // Synchronised auto-start strap
	wire chain_ok = sync2_r[3] & sync2_r[2]; // Upstream both channels on
	wire short_s = sync2_r[1];
	wire cross_s = sync2_r[0];
	logic intf1_r;
	logic intf2_r;
	always_ff @(posedge core_clk) begin
		intf1_r <= internal_fault;
		intf2_r <= intf1_r;
	end

	////////////////////////////////////////////////////////////////
	// State and stored code
	op_state_t state_r;
	op_state_t state_nxt;
	logic [CODE_W-1:0] code_r; // Taught actuator code
	logic taught_r; // A code is held
	logic [2:0] fault_r; // Latched fault type
	logic open_seen_r; // Guard opened since fault
	logic teach_prev_r; // Teach request edge detect

	// Code acceptance per coding mode
	wire code_match = taught_r && (tag_code == code_r);
	wire accepted = tag_present && tag_valid_type &&
		((CODING_MODE == CODING_ACCEPT_ANY) ? 1'b1 : code_match);
	// Teaching allowed: pair-once only while untaught, re-pair always
	wire teach_ok = (CODING_MODE == CODING_REPAIRABLE) ||
		((CODING_MODE == CODING_PAIR_ONCE) && !taught_r);
	wire teach_go = teach_s && !teach_prev_r && teach_ok &&
		tag_present && tag_valid_type;
	// Output monitor faults checked continuously, before any switch-on
	wire fault_now = short_s || cross_s || intf2_r;
	wire [2:0] fault_type = intf2_r ? FAULT_INTERNAL :
		(cross_s ? FAULT_CROSS : (short_s ? FAULT_SHORT : FAULT_NONE));
	// Release condition: guard open means actuator out of range
	wire out_on_ok = accepted && chain_ok && (start_s || auto_s);
	wire guard_open = !tag_present;

	// Next-state decode
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (fault_now) begin
					state_nxt = ST_FAULT;
				end else if (teach_go) begin
					state_nxt = ST_TEACH;
				end else if (out_on_ok) begin
					state_nxt = ST_RUN;
				end
			end
			ST_TEACH: begin
				// A fault seen while teaching must not be lost
				if (fault_now) begin
					state_nxt = ST_FAULT;
				end else begin
					state_nxt = ST_IDLE; // One cycle with outputs off
				end
			end
			ST_RUN: begin
				if (fault_now) begin
					state_nxt = ST_FAULT;
				end else if (!out_on_ok) begin
					// Lost actuator, open chain or start withdrawn
					state_nxt = ST_IDLE;
				end
			end
			ST_FAULT: begin
				// Clear only after cause gone and an open-close cycle
				if (!fault_now && open_seen_r && tag_present) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_FAULT;
		endcase
	end

	// State, code store, fault latch
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			code_r <= '0;
			taught_r <= 1'b0;
			fault_r <= FAULT_NONE;
			open_seen_r <= 1'b0;
			teach_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			teach_prev_r <= teach_s;
			if (state_r == ST_TEACH) begin
				code_r <= tag_code;
				taught_r <= 1'b1;
			end
			if (fault_now) begin
				fault_r <= fault_type;
			end else if (state_nxt != ST_FAULT) begin
				fault_r <= FAULT_NONE;
			end
			// Open seen only counts once the cause is gone
			if (state_r != ST_FAULT || fault_now) begin
				open_seen_r <= 1'b0;
			end else if (guard_open) begin
				open_seen_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Blink timebase and fault code pulse train
	logic [BLINK_W-1:0] blink_cnt_r;
	logic blink_r; // Slow toggle
	logic [3:0] phase_r; // Step in the code pattern
	wire blink_tick = (blink_cnt_r == BLINK_W'(BLINK_LEN - 1));
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
			phase_r <= 4'h0;
		end else if (blink_tick) begin
			blink_cnt_r <= '0;
			blink_r <= !blink_r;
			phase_r <= phase_r + 4'h1;
		end else begin
			blink_cnt_r <= blink_cnt_r + BLINK_W'(1);
		end
	end
	// Pulse n times then pause: even phases below 2*code are lit
	wire code_lit = !phase_r[0] && (phase_r[3:1] < fault_r);

	////////////////////////////////////////////////////////////////
	// Registered outputs
	wire in_safe = (state_nxt != ST_RUN) || fault_now;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			safety_out_ch1 <= 1'b0;
			safety_out_ch2 <= 1'b0;
			diagnostic_output <= 1'b1;
			diagnostic_indicator <= DIAG_OFF;
			state_indicator <= 1'b0;
			fault_code <= FAULT_NONE;
			paired <= 1'b0;
		end else begin
			safety_out_ch1 <= !in_safe;
			safety_out_ch2 <= !in_safe;
			diagnostic_output <= in_safe;
			fault_code <= fault_r;
			paired <= taught_r;
			if (state_r == ST_FAULT) begin
				diagnostic_indicator <= DIAG_RED;
				state_indicator <= code_lit;
			end else if (tag_present && tag_limit_range) begin
				diagnostic_indicator <= blink_r ? DIAG_YELLOW : DIAG_OFF;
				state_indicator <= (state_r == ST_RUN);
			end else begin
				diagnostic_indicator <= DIAG_GREEN;
				state_indicator <= (state_r == ST_RUN);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	fault_outs_off_a: assert property (@(posedge core_clk)
		disable iff (!resetn) (state_r == ST_FAULT) |=> !safety_out_ch1 && !safety_out_ch2)
		else $error("Outputs on during fault");
	channels_equal_a: assert property (@(posedge core_clk)
		disable iff (!resetn) safety_out_ch1 == safety_out_ch2)
		else $error("Safety channels differ");
	short_code_a: assert property (@(posedge core_clk)
		disable iff (!resetn) (short_s && !cross_s && !intf2_r) |=> fault_r == FAULT_SHORT)
		else $error("Short not latched as short fault");
	teach_safe_a: assert property (@(posedge core_clk)
		disable iff (!resetn) (state_r == ST_TEACH) |=> !safety_out_ch1)
		else $error("Outputs on during teaching");
	fault_detect_a: assert property (@(posedge core_clk)
		disable iff (!resetn) fault_now |=> state_r == ST_FAULT)
		else $error("Fault not latched");
	diag_inverse_a: assert property (@(posedge core_clk)
		disable iff (!resetn) ##1 diagnostic_output != safety_out_ch1)
		else $error("Diagnostic output not inverse");
	release_off_a: assert property (@(posedge core_clk)
		disable iff (!resetn) !tag_present |=> !safety_out_ch1)
		else $error("Outputs on without actuator");
	chain_off_a: assert property (@(posedge core_clk)
		disable iff (!resetn) !chain_ok |=> !safety_out_ch2)
		else $error("Outputs on with chain open");
	fault_red_a: assert property (@(posedge core_clk)
		disable iff (!resetn) (state_r == ST_FAULT) |=> diagnostic_indicator == DIAG_RED)
		else $error("Fault indicator not red");
	pair_once_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		(CODING_MODE == CODING_PAIR_ONCE && taught_r) |-> state_nxt != ST_TEACH)
		else $error("Pair-once retaught");
	run_cov: cover property (@(posedge core_clk) disable iff (!resetn) safety_out_ch1);
	teach_cov: cover property (@(posedge core_clk) disable iff (!resetn) state_r == ST_TEACH);
	recover_cov: cover property (@(posedge core_clk) disable iff (!resetn)
		state_r == ST_FAULT ##1 state_r == ST_IDLE);
endmodule // safety_switch_ctrl
`default_nettype wire

// ### inc/safety_switch_pkg.sv
`default_nettype none
package safety_switch_pkg;
	// Coding variants, fixed at build time
	localparam logic [1:0] CODING_PAIR_ONCE = 2'h0;
	localparam logic [1:0] CODING_REPAIRABLE = 2'h1;
	localparam logic [1:0] CODING_ACCEPT_ANY = 2'h2;
	// Actuator code width
	localparam int CODE_W = 32;
	// Indicator blink timing
	localparam int CLK_HZ = 40000000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
	localparam int BLINK_W = 24;
	// Fault type codes, blink count on the state indicator
	localparam logic [2:0] FAULT_NONE = 3'h0;
	localparam logic [2:0] FAULT_SHORT = 3'h1;
	localparam logic [2:0] FAULT_CROSS = 3'h2;
	localparam logic [2:0] FAULT_INTERNAL = 3'h3;
	// Indicator colour codes
	localparam logic [1:0] DIAG_OFF = 2'h0;
	localparam logic [1:0] DIAG_GREEN = 2'h1;
	localparam logic [1:0] DIAG_RED = 2'h2;
	localparam logic [1:0] DIAG_YELLOW = 2'h3;
	// Operating states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_TEACH = 4'h2,
		ST_RUN = 4'h4,
		ST_FAULT = 4'h8
	} op_state_t;
endpackage
`default_nettype wire

// ### bench/actuator_tag_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Coded actuator as the reader front end reports it
module actuator_tag_model
	import safety_switch_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Placement set by the bench
	input wire logic near,
	input wire logic edge_zone,
	input wire logic [CODE_W-1:0] code_id,
	// Reader side
	output var logic tag_present = 1'b0,
	output var logic tag_valid_type = 1'b0,
	output var logic [CODE_W-1:0] tag_code = '0,
	output var logic tag_limit_range = 1'b0
);
	// Code bits mean nothing once the tag leaves, so flip them
	always @(posedge core_clk) begin
		tag_present <= near;
		tag_valid_type <= near;
		tag_limit_range <= near & edge_zone;
		tag_code <= near ? code_id : ~tag_code;
	end
endmodule // actuator_tag_model
`default_nettype wire

// ### bench/rfid_safety_switch_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rfid_safety_switch_output_control_tb;
	import safety_switch_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic near = 1'b0;
	logic edge_zone = 1'b0;
	logic [CODE_W-1:0] code_id = 32'hA5A50001;
	logic teach_req = 1'b0, start_in = 1'b0, sh = 1'b0, cr = 1'b0, inf = 1'b0;
	logic auto_start = 1'b0;
	// One upstream switch only, far below thirty in series
	logic ch1 = 1'b1, ch2 = 1'b1;
	logic tp, tv, tl;
	logic [CODE_W-1:0] tc;
	logic [2:0] s1, s2, dgo, si, pr;
	logic [1:0] di [3];
	logic [2:0] fc [3];
	int err_total = 0, checks = 0;
	initial forever #12.5 core_clk = ~core_clk;
	actuator_tag_model tag (.core_clk(core_clk), .near(near), .edge_zone(edge_zone),
		.code_id(code_id), .tag_present(tp), .tag_valid_type(tv), .tag_code(tc),
		.tag_limit_range(tl));
	////////////////////////////////////////////////////////////
	// One sensor per coding variant, same stimulus
	for (genvar m = 0; m < 3; m++) begin : g_mode
		safety_switch_ctrl #(.CODING_MODE(2'(m)), .BLINK_LEN(4)) DUT (.core_clk(core_clk),
			.resetn(resetn), .tag_present(tp), .tag_valid_type(tv), .tag_code(tc),
			.tag_limit_range(tl), .teach_req(teach_req), .start_in(start_in),
			.auto_start(auto_start), .chain_in_ch1(ch1), .chain_in_ch2(ch2),
			.out_short_det(sh), .out_cross_det(cr), .internal_fault(inf),
			.safety_out_ch1(s1[m]), .safety_out_ch2(s2[m]), .diagnostic_output(dgo[m]),
			.diagnostic_indicator(di[m]), .state_indicator(si[m]), .fault_code(fc[m]),
			.paired(pr[m]));
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Let synchronisers settle, then both channels and the inverse
	task automatic outs(input logic [2:0] exp);
		tick(10);
		chk({5'h00, s1}, {5'h00, exp});
		chk({5'h00, s2}, {5'h00, exp});
		chk({5'h00, dgo}, {5'h00, ~exp});
	endtask
	task automatic teach;
		teach_req <= 1'b1;
		tick(6);
		teach_req <= 1'b0;
		tick(6);
	endtask
	task automatic finish_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_teach;
		near <= 1'b1;
		start_in <= 1'b1;
		outs(3'h4);
		teach();
		chk({5'h00, pr}, 8'h03);
		outs(3'h7);
		chk({5'h00, si}, 8'h07);
		chk({6'h00, di[1]}, {6'h00, DIAG_GREEN});
		start_in <= 1'b0;
		outs(3'h0);
		// Auto-start alone must switch on
		auto_start <= 1'b1;
		outs(3'h7);
		auto_start <= 1'b0;
		start_in <= 1'b1;
	endtask
	task automatic t_reteach;
		code_id <= 32'h5A5A0002;
		outs(3'h4);
		teach();
		outs(3'h6);
		code_id <= 32'hA5A50001;
		outs(3'h5);
		teach();
		outs(3'h7);
	endtask
	task automatic t_chain;
		ch2 <= 1'b0;
		outs(3'h0);
		ch2 <= 1'b1;
		ch1 <= 1'b0;
		outs(3'h0);
		ch1 <= 1'b1;
	endtask
	task automatic t_limit;
		int y = 0;
		int o = 0;
		edge_zone <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			if (di[1] === DIAG_YELLOW) y++;
			if (di[1] === DIAG_OFF) o++;
		end
		chk({7'h00, y > 0 && o > 0}, 8'h01);
		outs(3'h7);
		edge_zone <= 1'b0;
	endtask
	// Fault entry, lit count over one whole 16-step code pattern (64 cycles), then recovery
	task automatic t_fault(input logic [2:0] kind);
		int lit = 0;
		sh <= (kind == FAULT_SHORT);
		cr <= (kind == FAULT_CROSS);
		inf <= (kind == FAULT_INTERNAL);
		outs(3'h0);
		chk({6'h00, di[0]}, {6'h00, DIAG_RED});
		chk({5'h00, fc[1]}, {5'h00, kind});
		for (int i = 0; i < 64; i++) begin
			tick(1);
			if (si[2] === 1'b1) lit++;
		end
		chk(8'(lit), 8'(4 * kind));
		sh <= 1'b0;
		cr <= 1'b0;
		inf <= 1'b0;
		outs(3'h0);
		near <= 1'b0;
		outs(3'h0);
		near <= 1'b1;
		outs(3'h7);
	endtask
	// Fault that stays: only a power cycle (reset) clears it
	task automatic t_persist;
		inf <= 1'b1;
		start_in <= 1'b0;
		tick(10);
		start_in <= 1'b1;
		outs(3'h0);
		near <= 1'b0;
		tick(10);
		near <= 1'b1;
		outs(3'h0);
		inf <= 1'b0;
		resetn <= 1'b0;
		tick(5);
		resetn <= 1'b1;
		tick(3);
		chk({5'h00, pr}, 8'h00);
		outs(3'h4);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		resetn <= 1'b1;
		outs(3'h0);
		t_teach();
		t_reteach();
		t_chain();
		t_limit();
		for (int k = 1; k < 4; k++) t_fault(3'(k));
		t_persist();
		finish_test();
	end
endmodule // rfid_safety_switch_output_control_tb
`default_nettype wire
